/* bench/cfp_complex_fir_checker.sv */
// assertions on the complex fir top ports
`timescale 1ns/1ps
module cfp_complex_fir_checker
  import cfp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic ext_mode_i,
  input wire logic phase_first_o,
  input wire logic mux_is_imag_o,
  input wire logic mux_valid_o,
  input wire logic out_valid_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // -------------------------------------------------------------
  // phase and output rotation
  // -------------------------------------------------------------
  sequence s_quarter;
    (ext_mode_i && ce_i && phase_first_o)
      ##1 (ext_mode_i && ce_i && !phase_first_o)[*3];
  endsequence

  property p_ext_gap;
    ext_mode_i && ce_i && phase_first_o |=> !phase_first_o;
  endproperty
  property p_ext_period;
    s_quarter |=> phase_first_o;
  endproperty
  property p_dec2_toggle;
    !ext_mode_i && ce_i |=> phase_first_o != $past(phase_first_o);
  endproperty
  property p_freeze;
    !ce_i |=> $stable(phase_first_o);
  endproperty
  property p_mux_order;
    !ext_mode_i && mux_valid_o |-> mux_is_imag_o == phase_first_o;
  endproperty
  property p_mux_alt;
    !ext_mode_i && ce_i && mux_valid_o
      |=> mux_is_imag_o != $past(mux_is_imag_o);
  endproperty
  property p_mux_keep;
    !ext_mode_i && mux_valid_o |=> mux_valid_o;
  endproperty
  property p_out_keep;
    ext_mode_i && out_valid_o |=> out_valid_o;
  endproperty
  property p_out_quiet;
    !ext_mode_i |-> !out_valid_o;
  endproperty
  property p_mux_quiet;
    ext_mode_i |-> !mux_valid_o;
  endproperty

  a_ext_gap: assert property (p_ext_gap)
    else $error("phase mark held past first clock");
  a_ext_period: assert property (p_ext_period)
    else $error("phase mark missing after four clocks");
  a_dec2_toggle: assert property (p_dec2_toggle)
    else $error("phase mark not alternating");
  a_freeze: assert property (p_freeze)
    else $error("phase moved while disabled");
  a_mux_order: assert property (p_mux_order)
    else $error("mux component out of order");
  a_mux_alt: assert property (p_mux_alt)
    else $error("mux not alternating");
  a_mux_keep: assert property (p_mux_keep)
    else $error("mux valid dropped");
  a_out_keep: assert property (p_out_keep)
    else $error("group output valid dropped");
  a_out_quiet: assert property (p_out_quiet)
    else $error("group output valid in single mode");
  a_mux_quiet: assert property (p_mux_quiet)
    else $error("mux valid in extended mode");
endmodule

bind cfp_complex_fir cfp_complex_fir_checker cfp_complex_fir_checker_i (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .ext_mode_i(ext_mode_i),
  .phase_first_o(phase_first_o), .mux_is_imag_o(mux_is_imag_o),
  .mux_valid_o(mux_valid_o), .out_valid_o(out_valid_o));

/* bench/cfp_complex_fir_tb.sv */
// self-checking bench for the complex fir pair, both modes
`timescale 1ns/1ps
module cfp_complex_fir_tb;
  import cfp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic ext_mode_i = 1'b0;
  logic coef_we_i = 1'b0;
  logic [ADDR_W-1:0] coef_addr_i = 4'h0;
  logic [CW-1:0] coef_re_i = 16'h0;
  logic [CW-1:0] coef_im_i = 16'h0;
  logic [DW-1:0] sample_re_i;
  logic [DW-1:0] sample_im_i;
  logic phase_first_o;
  logic [AW-1:0] mux_out_o;
  logic mux_is_imag_o;
  logic mux_valid_o;
  logic [AW-1:0] out_re_o;
  logic [AW-1:0] out_im_o;
  logic out_valid_o;
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 71213;
  int t = 0;
  longint cr[16];
  longint ci[16];
  longint xr[4096];
  longint xi[4096];

  always #5 clk_i = ~clk_i;

  cfp_complex_fir cfp_complex_fir_i (.clk_i, .rst_n_i, .ce_i, .ext_mode_i,
    .sample_re_i, .sample_im_i, .coef_we_i, .coef_addr_i, .coef_re_i,
    .coef_im_i, .phase_first_o, .mux_out_o, .mux_is_imag_o, .mux_valid_o,
    .out_re_o, .out_im_o, .out_valid_o);

  cfp_sample_source cfp_sample_source_i (.clk_i,
    .phase_first_i(phase_first_o), .re_o(sample_re_i), .im_o(sample_im_i));

  // -------------------------------------------------------------
  // compare tasks and reference sums
  // -------------------------------------------------------------
  task automatic chk_val(logic [AW-1:0] got, logic [AW-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(logic got, logic exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [AW-1:0] expect_out(bit ext, bit im, int tt);
    longint acc;
    longint a;
    longint b;
    int s;
    int j;
    acc = 0;
    for (int p = 0; p < (ext ? 4 : 1); p++) begin
      for (int k = 0; k < 4; k++) begin
        s = ext ? tt - 6 + p - 4 * k : tt - (im ? 5 : 4) - 2 * k;
        j = ext ? 4 * p + 3 - k : 3 - k;
        a = ext ? xr[s] : xr[s - 1];
        b = ext ? xi[s] : xr[s];
        acc += im ? a * ci[j] + b * cr[j] : a * cr[j] - b * ci[j];
      end
    end
    return acc[AW-1:0];
  endfunction

  // score every enabled cycle, then log its samples
  always @(posedge clk_i) begin
    if (rst_n_i && ce_i) begin
      chk_flag(phase_first_o, ext_mode_i ? t % 4 == 0 : t % 2 == 0);
      if (t >= 40 && ext_mode_i) begin
        chk_flag(out_valid_o, 1'b1);
        chk_val(out_re_o, expect_out(1'b1, 1'b0, t));
        chk_val(out_im_o, expect_out(1'b1, 1'b1, t));
      end
      if (t >= 40 && !ext_mode_i) begin
        chk_flag(mux_valid_o, 1'b1);
        chk_flag(mux_is_imag_o, t % 2 == 0);
        if (t % 2 == 1) chk_val(mux_out_o, expect_out(1'b0, 1'b0, t));
        else chk_val(mux_out_o, expect_out(1'b0, 1'b1, t));
      end
      xr[t] = longint'($signed(sample_re_i));
      xi[t] = longint'($signed(sample_im_i));
      t++;
    end
  end

  // -------------------------------------------------------------
  // stimulus
  // -------------------------------------------------------------
  task automatic load_coefs();
    logic [CW-1:0] r;
    logic [CW-1:0] m;
    for (int i = 0; i < NTAP; i++) begin
      @(posedge clk_i);
      r = (i == 15) ? 16'h8000 : 16'($random(seed));
      m = (i == 0) ? 16'h7fff : 16'($random(seed));
      coef_we_i <= 1'b1;
      coef_addr_i <= 4'(i);
      coef_re_i <= r;
      coef_im_i <= m;
      cr[i] = longint'($signed(r));
      ci[i] = longint'($signed(m));
    end
    @(posedge clk_i);
    coef_we_i <= 1'b0;
  endtask

  task automatic run_mode(bit ext, int n);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    ext_mode_i <= ext;
    repeat (16) @(posedge clk_i);
    t = 0;
    rst_n_i <= 1'b1;
    load_coefs();
    repeat (n) @(posedge clk_i);
    ce_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    $display("test ext=%0d done errors %0d", ext, error_cnt);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    run_mode(1'b0, 120);
    run_mode(1'b1, 120);
    run_mode(1'b0, 60);
    print_verdict();
  end

  // watchdog: about four times the planned run
  initial begin
    #30000;
    error_cnt++;
    print_verdict();
  end
endmodule

/* bench/cfp_sample_source.sv */
// sample source model feeding a word pair every clock
`timescale 1ns/1ps
module cfp_sample_source
  import cfp_pkg::*;
(
  input wire logic clk_i,
  input wire logic phase_first_i,
  output logic [DW-1:0] re_o,
  output logic [DW-1:0] im_o
);
  int seed = 71213;
  int n = 0;

  initial begin
    re_o = 16'h0;
    im_o = 16'h0;
  end

  // random words, full-scale corners on both words, real ones only off the first phase
  always @(posedge clk_i) begin
    n <= n + 1;
    re_o <= (!phase_first_i && n % 5 == 0) ? 16'h8000
      : 16'($random(seed));
    im_o <= (n % 7 == 3) ? 16'h7fff : 16'($random(seed));
  end
endmodule

/* rtl/cfp_coef_bank.sv */
// coefficient store: sixteen complex coefficients in flops
`timescale 1ns/1ps
module cfp_coef_bank
  import cfp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [CW-1:0] re_i,
  input wire logic [CW-1:0] im_i,
  output cfp_cbank_t cr_o,
  output cfp_cbank_t ci_o
);

  cfp_cbank_t cr_q, cr_d, ci_q, ci_d;

  // write one entry per strobe
  always_comb begin
    cr_d = cr_q;
    ci_d = ci_q;
    if (we_i) begin
      cr_d[addr_i] = re_i;
      ci_d[addr_i] = im_i;
    end
  end

  // register the store
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cr_q <= {NTAP{COEF_RST}};
      ci_q <= {NTAP{COEF_RST}};
    end else if (ce_i) begin
      cr_q <= cr_d;
      ci_q <= ci_d;
    end
  end

  assign cr_o = cr_q;
  assign ci_o = ci_q;

endmodule

/* rtl/cfp_complex_fir.sv */
// top: complex fir from decimating section pairs, two modes
`timescale 1ns/1ps
module cfp_complex_fir
  import cfp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic ext_mode_i,
  input wire logic [DW-1:0] sample_re_i,
  input wire logic [DW-1:0] sample_im_i,
  input wire logic coef_we_i,
  input wire logic [ADDR_W-1:0] coef_addr_i,
  input wire logic [CW-1:0] coef_re_i,
  input wire logic [CW-1:0] coef_im_i,
  output logic phase_first_o,
  output logic [AW-1:0] mux_out_o,
  output logic mux_is_imag_o,
  output logic mux_valid_o,
  output logic [AW-1:0] out_re_o,
  output logic [AW-1:0] out_im_o,
  output logic out_valid_o
);

  // -------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------
  cfp_cbank_t cr_w;
  cfp_cbank_t ci_w;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] sec_cnt;
  logic ph_first_q, ph_first_d;
  logic [AW-1:0] res_w [NGRP][NFILT][NSEC];
  logic val_w [NGRP][NFILT][NSEC];

  // single-unit holding registers and output mux
  logic [AW-1:0] hold_re_q, hold_re_d;
  logic [AW-1:0] hold_im_q, hold_im_d;
  logic hold_ok_q, hold_ok_d;
  logic mux_imag_q, mux_imag_d;
  logic [AW-1:0] mux_out_q, mux_out_d;
  logic mux_is_imag_q, mux_is_imag_d;
  logic mux_valid_q, mux_valid_d;

  // extended group outputs
  logic [AW-1:0] out_re_q, out_re_d;
  logic [AW-1:0] out_im_q, out_im_d;
  logic out_valid_q, out_valid_d;
  logic [CNT_W-1:0] rot;

  // -------------------------------------------------------------
  // coefficient store
  // -------------------------------------------------------------
  cfp_coef_bank u_coef (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .we_i(coef_we_i),
    .addr_i(coef_addr_i),
    .re_i(coef_re_i),
    .im_i(coef_im_i),
    .cr_o(cr_w),
    .ci_o(ci_w)
  );

  // -------------------------------------------------------------
  // phase counter
  // -------------------------------------------------------------
  // counts every enabled clock; mode picks how many bits matter
  always_comb begin
    cnt_d = cnt_q + CNT_STEP;
    if (ext_mode_i) begin
      ph_first_d = (cnt_d == PH_FIRST);
    end else begin
      ph_first_d = (cnt_d[0] == PH_FIRST[0]);
    end
  end

  // register the counter and the phase mark
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= CNT_RST;
      ph_first_q <= 1'b1;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
      ph_first_q <= ph_first_d;
    end
  end

  // samples reach the first delay register one clock late
  assign sec_cnt = cnt_q - CNT_STEP;

  // -------------------------------------------------------------
  // section array: groups x filters x sections
  // -------------------------------------------------------------
  // group 0 builds the real output, group 1 the imaginary one
  for (genvar g = 0; g < NGRP; g++) begin : g_grp
    // four filters per group, never more than the decimation
    for (genvar f = 0; f < NFILT; f++) begin : g_filt
      for (genvar s = 0; s < NSEC; s++) begin : g_sec
        logic [CNT_W-1:0] ph;
        logic first_w;
        logic last_w;
        logic neg_w;
        logic use_im;
        logic [DW-1:0] x_w;
        cfp_ctap_t ctap;

        // phase, data and coefficient selection of this section
        always_comb begin
          ph = PH_FIRST;
          x_w = sample_re_i;
          neg_w = 1'b0;
          ctap = '0;
          if (ext_mode_i) begin
            // filters run one clock apart
            ph = sec_cnt - CNT_W'(f);
            last_w = (ph == PH_LAST_EXT);
            // first section real samples, second imaginary
            x_w = (s == 0) ? sample_re_i : sample_im_i;
            // real group: rr and ii; imaginary group: ri and ir
            use_im = ((g ^ s) == 1);
            for (int k = 0; k < NMUL; k++) begin
              // phase p, tap k takes coefficient 4p+3-k
              if (use_im) begin
                ctap[k] = ci_w[{ph, CNT_W'(NMUL-1-k)}];
              end else begin
                ctap[k] = cr_w[{ph, CNT_W'(NMUL-1-k)}];
              end
            end
          end else begin
            // one section pair, interleaved real/imag stream
            ph = {1'b0, sec_cnt[0]};
            last_w = (ph == PH_LAST_SINGLE);
            // coefficient set swaps every clock
            use_im = ((g ^ ph[0]) == 1);
            // real section subtracts the ii products
            neg_w = (g == 0) && (ph == PH_LAST_SINGLE);
            for (int k = 0; k < NMUL; k++) begin
              if (use_im) begin
                ctap[k] = ci_w[NMUL-1-k];
              end else begin
                ctap[k] = cr_w[NMUL-1-k];
              end
            end
          end
          first_w = (ph == PH_FIRST);
        end

        cfp_fir_section u_sec (
          .clk_i(clk_i),
          .rst_n_i(rst_n_i),
          .ce_i(ce_i),
          .dec4_i(ext_mode_i),
          .x_i(x_w),
          .coef_i(ctap),
          .first_i(first_w),
          .last_i(last_w),
          .neg_i(neg_w),
          .res_o(res_w[g][f][s]),
          .res_valid_o(val_w[g][f][s])
        );
      end
    end
  end

  // -------------------------------------------------------------
  // single unit: holding registers
  // -------------------------------------------------------------
  // first section of group 0 is the real part, of group 1 imag
  always_comb begin
    hold_re_d = hold_re_q;
    hold_im_d = hold_im_q;
    hold_ok_d = hold_ok_q;
    mux_imag_d = 1'b1;
    if (ext_mode_i) begin
      hold_ok_d = 1'b0;
    end else if (val_w[0][0][0]) begin
      hold_re_d = res_w[0][0][0];
      hold_im_d = res_w[1][0][0];
      hold_ok_d = 1'b1;
      mux_imag_d = 1'b0;
    end
  end

  // register the holding stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_re_q <= ACC_RST;
      hold_im_q <= ACC_RST;
      hold_ok_q <= 1'b0;
      mux_imag_q <= 1'b0;
    end else if (ce_i) begin
      hold_re_q <= hold_re_d;
      hold_im_q <= hold_im_d;
      hold_ok_q <= hold_ok_d;
      mux_imag_q <= mux_imag_d;
    end
  end

  // -------------------------------------------------------------
  // single unit: output multiplexer
  // -------------------------------------------------------------
  // real part one clock, imaginary part the next
  always_comb begin
    mux_out_d = mux_imag_q ? hold_im_q : hold_re_q;
    mux_is_imag_d = mux_imag_q;
    mux_valid_d = hold_ok_q && !ext_mode_i;
  end

  // register the multiplexed output
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mux_out_q <= ACC_RST;
      mux_is_imag_q <= 1'b0;
      mux_valid_q <= 1'b0;
    end else if (ce_i) begin
      mux_out_q <= mux_out_d;
      mux_is_imag_q <= mux_is_imag_d;
      mux_valid_q <= mux_valid_d;
    end
  end

  // -------------------------------------------------------------
  // extended: rotating group multiplexer
  // -------------------------------------------------------------
  // the filter whose result landed last clock is sec_cnt
  assign rot = sec_cnt;

  // combine the two section sums of the selected filter
  always_comb begin
    out_re_d = out_re_q;
    out_im_d = out_im_q;
    out_valid_d = 1'b0;
    if (ext_mode_i && val_w[0][rot][0]) begin
      // rotate through the four filters every clock
      out_re_d = res_w[0][rot][0] - res_w[0][rot][1];
      out_im_d = res_w[1][rot][0] + res_w[1][rot][1];
      out_valid_d = 1'b1;
    end
  end

  // register the group outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_re_q <= ACC_RST;
      out_im_q <= ACC_RST;
      out_valid_q <= 1'b0;
    end else if (ce_i) begin
      out_re_q <= out_re_d;
      out_im_q <= out_im_d;
      out_valid_q <= out_valid_d;
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign phase_first_o = ph_first_q;
  assign mux_out_o = mux_out_q;
  assign mux_is_imag_o = mux_is_imag_q;
  assign mux_valid_o = mux_valid_q;
  assign out_re_o = out_re_q;
  assign out_im_o = out_im_q;
  assign out_valid_o = out_valid_q;

endmodule

/* rtl/cfp_fir_section.sv */
// one real fir section: delay line, four multipliers, accumulator
`timescale 1ns/1ps
module cfp_fir_section
  import cfp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic dec4_i,
  input wire logic [DW-1:0] x_i,
  input cfp_ctap_t coef_i,
  input wire logic first_i,
  input wire logic last_i,
  input wire logic neg_i,
  output logic [AW-1:0] res_o,
  output logic res_valid_o
);

  cfp_dline_t dl_q, dl_d;
  logic [AW-1:0] acc_q, acc_d, res_q, res_d;
  logic val_q, val_d;
  logic signed [AW-1:0] sum;
  logic signed [PW-1:0] prod;
  logic [DW-1:0] tap;

  // shift delay line, multiply taps, accumulate
  always_comb begin
    sum = '0;
    prod = '0;
    tap = DATA_RST;
    dl_d = {dl_q[DL_LEN-2:0], x_i};
    for (int k = 0; k < NMUL; k++) begin
      // spacing of two or four registers between multipliers
      tap = dec4_i ? dl_q[k*DEC_EXT] : dl_q[k*DEC_SINGLE];
      prod = $signed(tap) * $signed(coef_i[k]);
      sum = sum + AW'(prod);
    end
    if (neg_i) begin
      sum = -sum;
    end
    // restart on first phase, else keep summing
    acc_d = first_i ? sum : acc_q + sum;
    res_d = last_i ? acc_d : res_q;
    val_d = last_i;
  end

  // register state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dl_q <= {DL_LEN{DATA_RST}};
      acc_q <= ACC_RST;
      res_q <= ACC_RST;
      val_q <= 1'b0;
    end else if (ce_i) begin
      dl_q <= dl_d;
      acc_q <= acc_d;
      res_q <= res_d;
      val_q <= val_d;
    end
  end

  assign res_o = res_q;
  assign res_valid_o = val_q;

endmodule

/* rtl/cfp_pkg.sv */
// constants and types shared by the complex fir pair design
package cfp_pkg;

  // -------------------------------------------------------------
  // widths
  // -------------------------------------------------------------
  localparam int DW = 16;
  localparam int CW = 16;
  localparam int PW = DW + CW;
  localparam int AW = 40;
  localparam int NMUL = 4;
  localparam int NTAP = 16;
  localparam int NGRP = 2;
  localparam int NSEC = 2;
  localparam int CNT_W = 2;
  localparam int ADDR_W = 4;

  // -------------------------------------------------------------
  // decimation and grouping
  // -------------------------------------------------------------
  localparam int DEC_SINGLE = 2;
  localparam int DEC_EXT = 4;
  localparam int MAX_DECIM = 4;
  localparam int NFILT = MAX_DECIM;
  localparam int DL_LEN = NMUL * DEC_EXT;
  localparam logic [CNT_W-1:0] PH_FIRST = 2'h0;
  localparam logic [CNT_W-1:0] PH_LAST_SINGLE = 2'h1;
  localparam logic [CNT_W-1:0] PH_LAST_EXT = 2'h3;
  localparam logic [CNT_W-1:0] CNT_STEP = 2'h1;

  // -------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_RST = 2'h0;
  localparam logic [AW-1:0] ACC_RST = 40'h0;
  localparam logic [DW-1:0] DATA_RST = 16'h0;
  localparam logic [CW-1:0] COEF_RST = 16'h0;

  typedef logic [NMUL-1:0][CW-1:0] cfp_ctap_t;
  typedef logic [NTAP-1:0][CW-1:0] cfp_cbank_t;
  typedef logic [DL_LEN-1:0][DW-1:0] cfp_dline_t;

endpackage
